// file: src/cprd_pkg.sv
/*
 * Constants for the call-progress transmit gain and ring-delay register bank:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a single 20 MHz clock and a byte-wide register port.
 */
package cprd_pkg;
   // Register offsets as printed, byte-wide port
   localparam logic [7:0] OFS_TX_GAIN = 8'h15;
   localparam logic [7:0] OFS_RING_A = 8'h16;
   localparam logic [7:0] OFS_RING_B = 8'h17;
   // Field positions
   localparam int RDLY_LO_MSB = 7;
   localparam int RDLY_LO_LSB = 6;
   localparam int RMAX_MSB = 5;
   localparam int RMAX_LSB = 0;
   localparam int RDLY_HI_BIT = 7;
   // Reset values; unity gain so the monitor starts transparent
   localparam logic [7:0] RST_TX_GAIN = 8'h40;
   localparam logic [1:0] RST_RDLY_LO = 2'h0;
   localparam logic [5:0] RST_RMAX = 6'h00;
   localparam logic RST_RDLY_HI = 1'b0;
   localparam logic [7:0] GAIN_MUTE = 8'h00;
   localparam logic [7:0] GAIN_UNITY = 8'h40;
   // Gain word is a fixed-point ratio over 64
   localparam int GAIN_SHIFT = 6;
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
   localparam int DELAY_STEP_MS = 256;
   localparam int DELAY_MS_W = 11;
endpackage : cprd_pkg

// file: src/cprd_tx_scale.sv
/*
 * Transmit-path gain stage for the call-progress monitor output.
 * Assumes samples are two's complement and arrive with a one-cycle valid.
 */
`timescale 1ns/1ps
module cprd_tx_scale
   import cprd_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] sample_i,
   input wire logic valid_i,
   input wire logic [7:0] gain_i,
   output logic [W-1:0] sample_o,
   output logic valid_o
);
   localparam logic signed [W+8:0] SAT_MAX = (W+9)'((2 ** (W-1)) - 1);
   localparam logic signed [W+8:0] SAT_MIN = -(W+9)'(2 ** (W-1));

   logic signed [W+8:0] prod;
   logic signed [W+8:0] shifted;
   logic [W-1:0] sample_r, sample_nxt;
   logic valid_r, valid_nxt;

   // Multiply, shift by six, then clamp so +12 dB cannot wrap
   always_comb begin
      // Operands widened first so the product is never cut to the sample width
      prod = $signed({{9{sample_i[W-1]}}, sample_i}) * $signed({{(W+1){1'b0}}, gain_i});
      shifted = prod >>> GAIN_SHIFT;
      valid_nxt = valid_i;
      sample_nxt = sample_r;
      if (valid_i) begin
         if (gain_i == GAIN_MUTE) begin
            sample_nxt = '0;
         end else if (shifted > SAT_MAX) begin
            sample_nxt = W'(SAT_MAX);
         end else if (shifted < SAT_MIN) begin
            sample_nxt = W'(SAT_MIN);
         end else begin
            sample_nxt = W'(shifted);
         end
      end
   end

   // Output register; last sample holds between strobes
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sample_r <= '0;
         valid_r <= 1'b0;
      end else begin
         sample_r <= sample_nxt;
         valid_r <= valid_nxt;
      end
   end

   assign sample_o = sample_r;
   assign valid_o = valid_r;
endmodule : cprd_tx_scale

// file: src/cprd_top.sv
/*
 * Call-progress transmit gain and ring-delay register bank with the
 * transmit monitor scaler and the ring indication delay timer.
 * Assumes a byte-wide register port with one-cycle strobes and all inputs
 * synchronous to the 20 MHz clock.
 */
`timescale 1ns/1ps
module cprd_top
   import cprd_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int MS_CYC = MS_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rd_data_o,
   input wire logic [SAMPLE_W-1:0] tx_sample_i,
   input wire logic tx_sample_valid_i,
   output logic [SAMPLE_W-1:0] call_progress_monitor_out_o,
   output logic call_progress_monitor_valid_o,
   input wire logic ring_validated_i,
   output logic ring_indicate_o,
   output logic [5:0] ring_period_max_o
);
   localparam int PRE_W = $clog2(MS_CYC + 1);

   logic [7:0] monitor_tx_gain_r, monitor_tx_gain_nxt;
   logic [1:0] ring_indicate_delay_r, ring_indicate_delay_nxt;
   logic [5:0] ring_period_max_r, ring_period_max_nxt;
   logic ring_indicate_delay_msb_r, ring_indicate_delay_msb_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic [2:0] delay_code;
   logic [DELAY_MS_W-1:0] delay_target;

   // Register writes; fields of the second ring register other than bit 7 are not held here
   always_comb begin
      monitor_tx_gain_nxt = monitor_tx_gain_r;
      ring_indicate_delay_nxt = ring_indicate_delay_r;
      ring_period_max_nxt = ring_period_max_r;
      ring_indicate_delay_msb_nxt = ring_indicate_delay_msb_r;
      if (wr_i) begin
         unique case (addr_i)
            OFS_TX_GAIN: begin
               monitor_tx_gain_nxt = wr_data_i;
            end
            OFS_RING_A: begin
               ring_indicate_delay_nxt = wr_data_i[RDLY_LO_MSB:RDLY_LO_LSB];
               ring_period_max_nxt = wr_data_i[RMAX_MSB:RMAX_LSB];
            end
            OFS_RING_B: begin
               ring_indicate_delay_msb_nxt = wr_data_i[RDLY_HI_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux; unmapped offsets and unheld bits read zero
   always_comb begin
      rd_data_nxt = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            OFS_TX_GAIN: begin
               rd_data_nxt = monitor_tx_gain_r;
            end
            OFS_RING_A: begin
               rd_data_nxt = {ring_indicate_delay_r, ring_period_max_r};
            end
            OFS_RING_B: begin
               rd_data_nxt = {ring_indicate_delay_msb_r, 7'h00};
            end
            default: begin
               rd_data_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         monitor_tx_gain_r <= RST_TX_GAIN;
         ring_indicate_delay_r <= RST_RDLY_LO;
         ring_period_max_r <= RST_RMAX;
         ring_indicate_delay_msb_r <= RST_RDLY_HI;
         rd_data_r <= 8'h00;
      end else begin
         monitor_tx_gain_r <= monitor_tx_gain_nxt;
         ring_indicate_delay_r <= ring_indicate_delay_nxt;
         ring_period_max_r <= ring_period_max_nxt;
         ring_indicate_delay_msb_r <= ring_indicate_delay_msb_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data_o = rd_data_r;
   // Period limit is only held; qualification logic lives elsewhere
   assign ring_period_max_o = ring_period_max_r;

   // Transmit monitor path
   cprd_tx_scale #(
      .W(SAMPLE_W)
   ) u_tx_scale (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sample_i(tx_sample_i),
      .valid_i(tx_sample_valid_i),
      .gain_i(monitor_tx_gain_r),
      .sample_o(call_progress_monitor_out_o),
      .valid_o(call_progress_monitor_valid_o)
   );

   // Delay code from both registers, 256 ms per step
   assign delay_code = {ring_indicate_delay_msb_r, ring_indicate_delay_r};
   assign delay_target = DELAY_MS_W'(delay_code) * DELAY_MS_W'(DELAY_STEP_MS);

   logic [PRE_W-1:0] pre_r, pre_nxt;
   logic ms_tick;
   logic [DELAY_MS_W-1:0] ms_cnt_r, ms_cnt_nxt;
   logic ring_ind_r, ring_ind_nxt;

   // Millisecond enable; restarts with each validated ring so the delay is not short by up to 1 ms
   always_comb begin
      ms_tick = 1'b0;
      pre_nxt = '0;
      if (ring_validated_i) begin
         if (pre_r == PRE_W'(MS_CYC - 1)) begin
            ms_tick = 1'b1;
         end else begin
            pre_nxt = pre_r + PRE_W'(1);
         end
      end
   end

   // Delay count; saturates at the target so a long ring cannot wrap
   always_comb begin
      ms_cnt_nxt = ms_cnt_r;
      ring_ind_nxt = 1'b0;
      if (!ring_validated_i) begin
         ms_cnt_nxt = '0;
      end else begin
         if (ms_tick && ms_cnt_r < delay_target) begin
            ms_cnt_nxt = ms_cnt_r + DELAY_MS_W'(1);
         end
         ring_ind_nxt = (ms_cnt_r >= delay_target);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pre_r <= '0;
         ms_cnt_r <= '0;
         ring_ind_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         ms_cnt_r <= ms_cnt_nxt;
         ring_ind_r <= ring_ind_nxt;
      end
   end

   assign ring_indicate_o = ring_ind_r;

   // Checks
   logic signed [SAMPLE_W+8:0] exp_prod;
   logic signed [SAMPLE_W+8:0] exp_shift;
   logic fits;
   always_comb begin
      exp_prod = $signed({{9{tx_sample_i[SAMPLE_W-1]}}, tx_sample_i})
         * $signed({{(SAMPLE_W+1){1'b0}}, monitor_tx_gain_r});
      exp_shift = exp_prod >>> GAIN_SHIFT;
      fits = (exp_shift == (SAMPLE_W+9)'($signed(tx_sample_i) >>> 0) * 0 + exp_shift)
         && (exp_shift <= (SAMPLE_W+9)'((2 ** (SAMPLE_W-1)) - 1))
         && (exp_shift >= -(SAMPLE_W+9)'(2 ** (SAMPLE_W-1)));
   end

   sequence gain_write_s(logic [7:0] ofs);
      wr_i && addr_i == ofs;
   endsequence

   sequence read_back_s(logic [7:0] ofs);
      rd_i && addr_i == ofs && !wr_i;
   endsequence

   scale_linear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      tx_sample_valid_i && fits && !wr_i |=> call_progress_monitor_out_o == SAMPLE_W'($past(exp_shift)))
      else $error("monitor sample not gain over 64");

   unity_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      tx_sample_valid_i && monitor_tx_gain_r == GAIN_UNITY |=> call_progress_monitor_out_o == $past(tx_sample_i))
      else $error("unity gain changed the sample");

   mute_out_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      tx_sample_valid_i && monitor_tx_gain_r == GAIN_MUTE |=> call_progress_monitor_out_o == '0)
      else $error("mute code let signal through");

   sat_clamp_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      tx_sample_valid_i && !fits && exp_shift > 0 |=>
      call_progress_monitor_out_o == SAMPLE_W'((2 ** (SAMPLE_W-1)) - 1))
      else $error("positive overflow not saturated");

   ring_a_back_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      gain_write_s(OFS_RING_A) ##1 read_back_s(OFS_RING_A) |=> rd_data_o == $past(wr_data_i, 2))
      else $error("ring register A readback wrong");

   ring_b_back_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      gain_write_s(OFS_RING_B) ##1 read_back_s(OFS_RING_B) |=> rd_data_o == {$past(wr_data_i[7], 2), 7'h00})
      else $error("ring delay top bit readback wrong");

   ring_delay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(ring_indicate_o) |-> $past(ms_cnt_r) >= $past(delay_target) && $past(ring_validated_i))
      else $error("ring indicated before delay ran out");

   zero_delay_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ring_validated_i && delay_code == 3'h0 && !wr_i |=> ring_indicate_o)
      else $error("zero delay code did not indicate at once");
endmodule : cprd_top

// file: bench/call_progress_tx_atten_ring_delay_test.sv
/*
 * Self-checking bench for the call-progress transmit gain and ring-delay
 * register bank: register access, monitor scaling and ring indication delay.
 * Assumes cprd_top and cprd_pkg are compiled first and one 20 MHz clock.
 */
`timescale 1ns/1ps
module call_progress_tx_atten_ring_delay_test import cprd_pkg::*;;
   // Shortened millisecond so the longest delay stays a few thousand cycles
   localparam int MS_CYC = 4;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wr_data_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] rd_data_o;
   logic [15:0] tx_sample_i = 16'h0000;
   logic tx_sample_valid_i = 1'b0;
   logic [15:0] call_progress_monitor_out_o;
   logic call_progress_monitor_valid_o;
   logic ring_validated_i = 1'b0;
   logic ring_indicate_o;
   logic [5:0] ring_period_max_o;
   int err_count = 0;
   int checks = 0;
   logic [7:0] gains [6] = '{8'hFF, 8'h7F, 8'h40, 8'h20, 8'h10, 8'h00};
   int smp [4] = '{100, -100, 32767, -32768};
   logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};

   cprd_top #(.SAMPLE_W(16), .MS_CYC(MS_CYC)) u_cprd_top (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .addr_i(addr_i),
      .wr_data_i(wr_data_i),
      .wr_i(wr_i),
      .rd_i(rd_i),
      .rd_data_o(rd_data_o),
      .tx_sample_i(tx_sample_i),
      .tx_sample_valid_i(tx_sample_valid_i),
      .call_progress_monitor_out_o(call_progress_monitor_out_o),
      .call_progress_monitor_valid_o(call_progress_monitor_valid_o),
      .ring_validated_i(ring_validated_i),
      .ring_indicate_o(ring_indicate_o),
      .ring_period_max_o(ring_period_max_o)
   );

   // 50 ns period clock
   initial begin
      forever #25 clk_i = ~clk_i;
   end

   // Case inequality so an unknown never counts as a match
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   // Strobe stands for one edge; the next access may follow with no gap, bus_idle ends a burst
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      rd_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe edge
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      addr_i <= a;
      rd_i <= 1'b1;
      wr_i <= 1'b0;
      @(posedge clk_i);
      #1;
      check({8'h00, rd_data_o}, {8'h00, exp});
   endtask : rd_reg

   // Drop both strobes before non-bus activity
   task automatic bus_idle();
      wr_i <= 1'b0;
      rd_i <= 1'b0;
   endtask : bus_idle

   // Expected result: floor of sample times gain over 64, clipped to 16 bits
   task automatic scale(input int s, input logic [7:0] g);
      int p;
      p = (s * int'(g)) >>> GAIN_SHIFT;
      p = (p > 32767) ? 32767 : p;
      p = (p < -32768) ? -32768 : p;
      wr_reg(OFS_TX_GAIN, g);
      bus_idle();
      tx_sample_i <= s[15:0];
      tx_sample_valid_i <= 1'b1;
      @(posedge clk_i);
      tx_sample_valid_i <= 1'b0;
      #1;
      check({15'h0000, call_progress_monitor_valid_o}, 16'h0001);
      check(call_progress_monitor_out_o, p[15:0]);
   endtask : scale

   // Counts cycles from ring valid to indication; bound cuts a hang short
   task automatic ring(input logic [2:0] code);
      int n;
      int exp;
      exp = (code == 3'h0) ? 1 : int'(code) * DELAY_STEP_MS * MS_CYC;
      wr_reg(OFS_RING_A, {code[1:0], 6'h2A});
      wr_reg(OFS_RING_B, {code[2], 7'h7F});
      rd_reg(OFS_RING_A, {code[1:0], 6'h2A});
      rd_reg(OFS_RING_B, {code[2], 7'h00});
      bus_idle();
      check({10'h000, ring_period_max_o}, 16'h002A);
      @(posedge clk_i);
      ring_validated_i <= 1'b1;
      n = 0;
      while (ring_indicate_o !== 1'b1 && n < 6000) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      if (n >= 6000) begin
         err_count++;
         close_out();
      end
      check({15'h0000, (n >= exp && n <= exp + 3)}, 16'h0001);
      @(posedge clk_i);
      ring_validated_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check({15'h0000, ring_indicate_o}, 16'h0000);
   endtask : ring

   // Main sequence: reset values, field map, gain table, delay codes
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd_reg(OFS_TX_GAIN, RST_TX_GAIN);
      rd_reg(OFS_RING_A, 8'h00);
      rd_reg(OFS_RING_B, 8'h00);
      wr_reg(8'h18, 8'hA5);
      rd_reg(8'h18, 8'h00);
      wr_reg(OFS_RING_A, 8'hC5);
      rd_reg(OFS_RING_A, 8'hC5);
      check({10'h000, ring_period_max_o}, 16'h0005);
      wr_reg(OFS_RING_B, 8'hFF);
      rd_reg(OFS_RING_B, 8'h80);
      foreach (gains[i]) begin
         foreach (smp[j]) begin
            scale(smp[j], gains[i]);
         end
      end
      foreach (codes[i]) begin
         ring(codes[i]);
      end
      close_out();
   end
endmodule : call_progress_tx_atten_ring_delay_test
